/* core/fsc_defs.svh */
// fsc_defs.svh: register offsets, field positions, reset values, link codes
// assumes: included by bare name into the shadow-config design files
`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH

// register addresses on the serial configuration port (9-bit)
`define FSC_A_BLACK_LEVEL_A    9'h080
`define FSC_A_BLACK_LEVEL_B    9'h081
`define FSC_A_SEQ_CTRL         9'h0C0
`define FSC_A_WIN_SEL          9'h0C3
`define FSC_A_BLACK_LINES      9'h0C5
`define FSC_A_DUMMY_LINES      9'h0C6
`define FSC_A_EXPOSURE         9'h0C7
`define FSC_A_GAIN             9'h0CC
`define FSC_A_SYNC_CFG         9'h0CE
`define FSC_A_STATUS           9'h0D0

// sequencer control fields
`define FSC_B_SEQ_EN           0
`define FSC_B_ROLLING          1
`define FSC_B_TRIGGERED        2
`define FSC_B_SLAVE            3
`define FSC_B_SUBSAMPLE        7
`define FSC_B_BINNING          8

// exposure control fields
`define FSC_B_EXP_IMMEDIATE    12
`define FSC_B_GAIN_LAT_COMP    13

// frame sync and blank configuration fields
`define FSC_B_SYNC_BLACK       1
`define FSC_B_SYNC_DUMMY       2
`define FSC_B_SYNC_EXPOSURE    3
`define FSC_B_SYNC_GAIN        4
`define FSC_B_SYNC_ROI         5
`define FSC_B_BLANK_ROI_SWITCH 8

// reset values
`define FSC_RST_WORD           16'h0000
`define FSC_RST_SYNC_CFG       16'h003E

// serial frame: 9 address bits, 1 write bit, 16 data bits
`define FSC_SPI_ADDR_LAST      5'h09
`define FSC_SPI_DATA_LAST      5'h19

// link words
`define FSC_TRAIN_WORD         10'h3A6
`define FSC_SYNC_FS            10'h2AA
`define FSC_SYNC_DV            10'h035

`endif

/* core/fsc_pkg.sv */
// fsc_pkg: types shared by the shadow-config design files
// assumes: nothing beyond the compiler
package fsc_pkg;

  typedef enum logic [1:0] {
    FSC_LK_IDLE   = 2'b00,
    FSC_LK_NORMAL = 2'b01,
    FSC_LK_BLANK  = 2'b10
  } fsc_lk_state_t;

  typedef struct packed {
    logic [15:0] exposure;
    logic [15:0] gain;
    logic [15:0] window;
    logic [15:0] black_lines;
    logic [15:0] dummy_lines;
    logic        subsample;
    logic        binning;
    logic        rolling;
  } fsc_act_t;

endpackage

/* core/fsc_evt_sync.sv */
// fsc_evt_sync: carries a toggle-coded event into another clock domain
// assumes: source toggles at most once per several destination cycles
`timescale 1ns/1ps
`default_nettype none

module fsc_evt_sync (
  input  wire logic dst_clk,
  input  wire logic dst_rstn,
  input  wire logic dst_ce,
  input  wire logic src_tgl,
  output logic      pulse
);

  logic [2:0] tgl_s;

  // first flop feeds only the second
  always_ff @(posedge dst_clk or negedge dst_rstn) begin
    if (!dst_rstn) begin
      tgl_s <= 3'h0;
    end else if (dst_ce) begin
      tgl_s <= {tgl_s[1:0], src_tgl};
    end
  end

  assign pulse = dst_ce & (tgl_s[1] ^ tgl_s[2]);

endmodule // fsc_evt_sync

`default_nettype wire

/* core/fsc_config_shadow.sv */
// fsc_config_shadow: frame-synchronised configuration shadow and blanking
// assumes: host on spi pins (mode 0, sck well below clk/4), free link_clk
`include "fsc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module fsc_config_shadow #(
  parameter int FRAME_CYCLES = 1024
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  output logic [15:0]      black_level_a,
  output logic [15:0]      black_level_b,
  input  wire logic        link_clk,
  input  wire logic [9:0]  pix_data,
  output logic [9:0]       data_out,
  output logic [9:0]       sync_out,
  output logic             frame_start,
  output logic             frame_blank,
  output fsc_pkg::fsc_act_t act_cfg
);

  if (FRAME_CYCLES < 16 || FRAME_CYCLES > 65536) begin : g_chk
    $error("FRAME_CYCLES out of range 16..65536");
  end

  localparam logic [15:0] LAST_CNT = 16'(FRAME_CYCLES - 1);

  function automatic logic [15:0] pick(input logic bypass,
                                       input logic [15:0] direct,
                                       input logic [15:0] staged);
    pick = bypass ? direct : staged;
  endfunction

  // ---------------- serial port, clk domain ----------------
  logic [2:0]  sck_s;
  logic [1:0]  cs_s;
  logic [1:0]  mosi_s;
  logic [4:0]  bit_cnt;
  logic [14:0] in_sh;
  logic [8:0]  addr_q;
  logic        wr_q;
  logic [15:0] out_sh;
  logic        miso_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_s  <= 3'h0;
      cs_s   <= 2'h3;
      mosi_s <= 2'h0;
    end else if (ce) begin
      sck_s  <= {sck_s[1:0], spi_sck};
      cs_s   <= {cs_s[0], spi_cs_n};
      mosi_s <= {mosi_s[0], spi_mosi};
    end
  end

  wire        cs_act    = ~cs_s[1];
  wire        sck_rise  = cs_act & sck_s[1] & ~sck_s[2];
  wire        sck_fall  = cs_act & ~sck_s[1] & sck_s[2];
  wire        addr_done = sck_rise && bit_cnt == `FSC_SPI_ADDR_LAST;
  wire        data_done = sck_rise && bit_cnt == `FSC_SPI_DATA_LAST;
  wire        wr_stb    = data_done & wr_q;
  wire [15:0] wr_data   = {in_sh, mosi_s[1]};
  wire [8:0]  new_addr  = in_sh[8:0];
  logic [15:0] rd_data;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt <= 5'h00;
      in_sh   <= 15'h0000;
      addr_q  <= 9'h000;
      wr_q    <= 1'b0;
      out_sh  <= 16'h0000;
      miso_q  <= 1'b0;
    end else if (ce) begin
      if (!cs_act) begin
        bit_cnt <= 5'h00;
      end else if (sck_rise) begin
        bit_cnt <= bit_cnt + 5'h01;
        in_sh   <= {in_sh[13:0], mosi_s[1]};
      end
      if (addr_done) begin
        addr_q <= new_addr;
        wr_q   <= mosi_s[1];
      end
      if (addr_done) begin
        out_sh <= rd_data;
      end else if (sck_fall) begin
        miso_q <= out_sh[15];
        out_sh <= {out_sh[14:0], 1'b0};
      end
    end
  end

  assign spi_miso    = miso_q;
  assign spi_miso_oe = cs_act;

  // ---------------- shadow registers ----------------
  logic [15:0] seq_ctrl;
  logic [15:0] win_sel;
  logic [15:0] black_lines;
  logic [15:0] dummy_lines;
  logic [15:0] exp_ctrl;
  logic [15:0] gain;
  logic [15:0] sync_cfg;

  wire we_blk_a = wr_stb && addr_q == `FSC_A_BLACK_LEVEL_A;
  wire we_blk_b = wr_stb && addr_q == `FSC_A_BLACK_LEVEL_B;
  wire we_seq   = wr_stb && addr_q == `FSC_A_SEQ_CTRL;
  wire we_win   = wr_stb && addr_q == `FSC_A_WIN_SEL;
  wire we_black = wr_stb && addr_q == `FSC_A_BLACK_LINES;
  wire we_dummy = wr_stb && addr_q == `FSC_A_DUMMY_LINES;
  wire we_exp   = wr_stb && addr_q == `FSC_A_EXPOSURE;
  wire we_gain  = wr_stb && addr_q == `FSC_A_GAIN;
  wire we_sync  = wr_stb && addr_q == `FSC_A_SYNC_CFG;

  // black level words drive the calibration directly
  // other dynamic groups reach the active set only at the frame-boundary load
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      black_level_a <= `FSC_RST_WORD;
      black_level_b <= `FSC_RST_WORD;
      seq_ctrl      <= `FSC_RST_WORD;
      win_sel       <= `FSC_RST_WORD;
      black_lines   <= `FSC_RST_WORD;
      dummy_lines   <= `FSC_RST_WORD;
      exp_ctrl      <= `FSC_RST_WORD;
      gain          <= `FSC_RST_WORD;
      sync_cfg      <= `FSC_RST_SYNC_CFG;
    end else if (ce) begin
      if (we_blk_a) black_level_a <= wr_data;
      if (we_blk_b) black_level_b <= wr_data;
      if (we_seq)   seq_ctrl      <= wr_data;
      if (we_win)   win_sel       <= wr_data;
      if (we_black) black_lines   <= wr_data;
      if (we_dummy) dummy_lines   <= wr_data;
      if (we_exp)   exp_ctrl      <= wr_data;
      if (we_gain)  gain          <= wr_data;
      if (we_sync)  sync_cfg      <= wr_data;
    end
  end

  // ---------------- frame-boundary load, clk domain ----------------
  logic              sof_tgl;
  logic              load;
  logic [1:0]        run_s;
  logic              mode_rolling;
  logic              mode_trig;
  logic              mode_slave;
  logic [15:0]       exp_stage;
  logic [15:0]       gain_stage;
  fsc_pkg::fsc_act_t act_q;
  logic              blank_q;
  logic              cfg_tgl;
  logic [7:0]        frame_cnt;
  logic              link_running;

  fsc_evt_sync u_sof_sync (
    .dst_clk  (clk),
    .dst_rstn (resetn),
    .dst_ce   (ce),
    .src_tgl  (sof_tgl),
    .pulse    (load)
  );

  wire running_c = run_s[1];
  wire s_black   = sync_cfg[`FSC_B_SYNC_BLACK];
  wire s_dummy   = sync_cfg[`FSC_B_SYNC_DUMMY];
  wire s_exp     = sync_cfg[`FSC_B_SYNC_EXPOSURE];
  wire s_gain    = sync_cfg[`FSC_B_SYNC_GAIN];
  wire s_roi     = sync_cfg[`FSC_B_SYNC_ROI];
  wire blank_roi = sync_cfg[`FSC_B_BLANK_ROI_SWITCH];
  wire lat_comp  = exp_ctrl[`FSC_B_GAIN_LAT_COMP];
  wire exp_imm   = mode_trig & ~mode_slave & ~mode_rolling &
                   exp_ctrl[`FSC_B_EXP_IMMEDIATE];
  wire chg_black = s_black && black_lines != act_q.black_lines;
  wire chg_dummy = s_dummy && dummy_lines != act_q.dummy_lines;
  wire chg_win   = s_roi && blank_roi && win_sel != act_q.window;
  wire next_blank = mode_rolling & (chg_black | chg_dummy | chg_win);
  wire idle_c    = ~running_c & ~seq_ctrl[`FSC_B_SEQ_EN];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_s <= 2'h0;
    end else if (ce) begin
      run_s <= {run_s[0], link_running};
    end
  end

  // static mode bits follow the host only while stopped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_rolling <= 1'b0;
      mode_trig    <= 1'b0;
      mode_slave   <= 1'b0;
    end else if (ce && idle_c) begin
      mode_rolling <= seq_ctrl[`FSC_B_ROLLING];
      mode_trig    <= seq_ctrl[`FSC_B_TRIGGERED];
      mode_slave   <= seq_ctrl[`FSC_B_SLAVE];
    end
  end

  // active set moves only on the single start-of-frame load; groups with a clear sync bit hold
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exp_stage  <= `FSC_RST_WORD;
      gain_stage <= `FSC_RST_WORD;
      act_q      <= '0;
      blank_q    <= 1'b0;
      cfg_tgl    <= 1'b0;
      frame_cnt  <= 8'h00;
    end else if (load) begin
      if (s_exp) begin
        exp_stage      <= exp_ctrl;
        act_q.exposure <= pick(exp_imm, exp_ctrl, exp_stage);
      end
      if (s_gain) begin
        gain_stage <= gain;
        act_q.gain <= pick(lat_comp, gain_stage, gain);
      end
      if (s_roi) begin
        act_q.window    <= win_sel;
        act_q.subsample <= seq_ctrl[`FSC_B_SUBSAMPLE];
        act_q.binning   <= seq_ctrl[`FSC_B_BINNING];
      end
      if (s_black) act_q.black_lines <= black_lines;
      if (s_dummy) act_q.dummy_lines <= dummy_lines;
      act_q.rolling <= mode_rolling;
      blank_q       <= next_blank;
      cfg_tgl       <= ~cfg_tgl;
      frame_cnt     <= frame_cnt + 8'h01;
    end
  end

  wire [15:0] status_w = {frame_cnt, 6'h00, blank_q, running_c};

  assign rd_data =
    (new_addr == `FSC_A_BLACK_LEVEL_A) ? black_level_a :
    (new_addr == `FSC_A_BLACK_LEVEL_B) ? black_level_b :
    (new_addr == `FSC_A_SEQ_CTRL)      ? seq_ctrl      :
    (new_addr == `FSC_A_WIN_SEL)       ? win_sel       :
    (new_addr == `FSC_A_BLACK_LINES)   ? black_lines   :
    (new_addr == `FSC_A_DUMMY_LINES)   ? dummy_lines   :
    (new_addr == `FSC_A_EXPOSURE)      ? exp_ctrl      :
    (new_addr == `FSC_A_GAIN)          ? gain          :
    (new_addr == `FSC_A_SYNC_CFG)      ? sync_cfg      :
    (new_addr == `FSC_A_STATUS)        ? status_w      : 16'h0000;

  // ---------------- link domain ----------------
  logic [1:0]             lrst;
  logic [1:0]             en_s;
  logic                   cfg_pulse;
  fsc_pkg::fsc_act_t      pend;
  logic                   pend_blank;
  fsc_pkg::fsc_lk_state_t state;
  logic [15:0]            cnt;

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      lrst <= 2'h0;
    end else begin
      lrst <= {lrst[0], 1'b1};
    end
  end

  wire link_rstn = lrst[1];

  fsc_evt_sync u_cfg_sync (
    .dst_clk  (link_clk),
    .dst_rstn (link_rstn),
    .dst_ce   (1'b1),
    .src_tgl  (cfg_tgl),
    .pulse    (cfg_pulse)
  );

  wire en_l     = en_s[1];
  wire last     = cnt == LAST_CNT;
  wire in_frame = state != fsc_pkg::FSC_LK_IDLE;
  // a started frame runs to its last cycle whatever the host writes
  wire start    = en_l & (~in_frame | last);
  wire stop     = ~en_l & in_frame & last;

  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      en_s       <= 2'h0;
      pend       <= '0;
      pend_blank <= 1'b0;
      state      <= fsc_pkg::FSC_LK_IDLE;
      cnt        <= 16'h0000;
      sof_tgl    <= 1'b0;
      act_cfg    <= '0;
      frame_start <= 1'b0;
    end else begin
      en_s        <= {en_s[0], seq_ctrl[`FSC_B_SEQ_EN]};
      frame_start <= start;
      if (start) begin
        act_cfg    <= pend;
        pend_blank <= 1'b0;
        sof_tgl    <= ~sof_tgl;
        cnt        <= 16'h0000;
        state      <= pend_blank ? fsc_pkg::FSC_LK_BLANK
                                 : fsc_pkg::FSC_LK_NORMAL;
      end else if (stop) begin
        state <= fsc_pkg::FSC_LK_IDLE;
      end else if (in_frame) begin
        cnt <= cnt + 16'h0001;
      end
      // a fresh capture wins over the clear at a frame start
      if (cfg_pulse) begin
        pend       <= act_q;
        pend_blank <= blank_q;
      end
    end
  end

  assign link_running = in_frame;
  assign frame_blank  = state == fsc_pkg::FSC_LK_BLANK;

  // training on both channels outside normal frames
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      data_out <= `FSC_TRAIN_WORD;
      sync_out <= `FSC_TRAIN_WORD;
    end else begin
      case (state)
        fsc_pkg::FSC_LK_NORMAL: begin
          data_out <= pix_data;
          sync_out <= (cnt == 16'h0000) ? `FSC_SYNC_FS : `FSC_SYNC_DV;
        end
        default: begin
          data_out <= `FSC_TRAIN_WORD;
          sync_out <= `FSC_TRAIN_WORD;
        end
      endcase
    end
  end

  // ---------------- assertions ----------------
  property p_hold_active;
    @(posedge clk) disable iff (!resetn) !load |=> $stable(act_q);
  endproperty
  a_hold_active: assert property (p_hold_active)
    else $error("active set changed without frame load");

  property p_blank_lines;
    @(posedge clk) disable iff (!resetn)
      load && mode_rolling && (chg_black || chg_dummy) |=> blank_q ##1
      (!load)[*1] ##0 blank_q;
  endproperty
  a_blank_lines: assert property (p_blank_lines)
    else $error("line count change did not blank");

  property p_no_blank_global;
    @(posedge clk) disable iff (!resetn) load && !mode_rolling |=> !blank_q;
  endproperty
  a_no_blank_global: assert property (p_no_blank_global)
    else $error("blank requested in global shutter");

  property p_win_blank;
    @(posedge clk) disable iff (!resetn)
      load && mode_rolling && s_roi && blank_roi &&
      win_sel != act_q.window |=> blank_q && act_q.window == $past(win_sel);
  endproperty
  a_win_blank: assert property (p_win_blank)
    else $error("window switch not blanked");

  property p_exp_latency;
    @(posedge clk) disable iff (!resetn)
      load && s_exp && !exp_imm |=> act_q.exposure == $past(exp_stage);
  endproperty
  a_exp_latency: assert property (p_exp_latency)
    else $error("exposure latency wrong");

  property p_gain_comp;
    @(posedge clk) disable iff (!resetn)
      load && s_gain |=> act_q.gain ==
        ($past(lat_comp) ? $past(gain_stage) : $past(gain));
  endproperty
  a_gain_comp: assert property (p_gain_comp)
    else $error("gain update latency wrong");

  property p_freeze;
    @(posedge clk) disable iff (!resetn)
      load && !s_gain |=> $stable(act_q.gain) &&
        ($past(s_roi) || $stable(act_q.window));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("frozen group was updated");

  property p_mode_idle;
    @(posedge clk) disable iff (!resetn)
      running_c |=> $stable(mode_rolling);
  endproperty
  a_mode_idle: assert property (p_mode_idle)
    else $error("shutter mode changed while running");

  property p_train;
    @(posedge link_clk) disable iff (!link_rstn)
      frame_blank |=> data_out == `FSC_TRAIN_WORD &&
        sync_out == `FSC_TRAIN_WORD;
  endproperty
  a_train: assert property (p_train)
    else $error("blank frame without training");

  property p_frame_len;
    @(posedge link_clk) disable iff (!link_rstn)
      frame_start |-> cnt == 16'h0000 ##1 (!frame_start)[*8];
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame shorter than its period");

  property p_run;
    @(posedge link_clk) disable iff (!link_rstn)
      in_frame && !last |=> in_frame;
  endproperty
  a_run: assert property (p_run)
    else $error("frame stopped before its end");

  c_blank: cover property (@(posedge link_clk) frame_blank);
  c_gain_comp: cover property (@(posedge clk) load && s_gain && lat_comp);
  c_exp_imm: cover property (@(posedge clk) load && s_exp && exp_imm);
  c_stop: cover property (@(posedge link_clk) stop);

endmodule // fsc_config_shadow

`default_nettype wire

/* sim/fsc_spi_host.sv */
// fsc_spi_host: host model on the serial configuration port
// assumes: clk at 50 MHz; sck phases of 5 clk, mode 0, msb first
`timescale 1ns/1ps
`default_nettype none

module fsc_spi_host (
  input  wire logic clk,
  input  wire logic spi_miso,
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_mosi
);
  initial begin
    spi_sck  = 1'h0;
    spi_cs_n = 1'h1;
    spi_mosi = 1'h0;
  end

  // 26 bits: address, write flag, data; read data taken at sck rise
  task automatic xfer(input logic [8:0] a, input logic w,
                      input logic [15:0] d, output logic [15:0] q);
    logic [25:0] f;
    f = {a, w, d};
    q = 16'h0000;
    @(posedge clk) spi_cs_n <= 1'h0;
    for (int i = 25; i >= 0; i--) begin
      spi_mosi <= f[i];
      repeat (5) @(posedge clk);
      spi_sck <= 1'h1;
      if (i < 16) q[i] = spi_miso;
      repeat (5) @(posedge clk);
      spi_sck <= 1'h0;
    end
    repeat (5) @(posedge clk);
    spi_cs_n <= 1'h1;
    // released data line no longer shows the last bit
    spi_mosi <= ~f[0];
    repeat (12) @(posedge clk);
  endtask
endmodule // fsc_spi_host

`default_nettype wire

/* sim/tb_frame_synced_config_shadow.sv */
// tb_frame_synced_config_shadow: self-checking bench with shadow model
// assumes: fsc_spi_host as host, free link clock, short frames
`timescale 1ns/1ps
`default_nettype none
`include "fsc_defs.svh"
`define CHK(g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); \
  end \
end

module tb_frame_synced_config_shadow;
  localparam int FC = 512;
  localparam logic [8:0] RA [9] = '{`FSC_A_BLACK_LEVEL_A,
    `FSC_A_BLACK_LEVEL_B, `FSC_A_SEQ_CTRL, `FSC_A_WIN_SEL,
    `FSC_A_BLACK_LINES, `FSC_A_DUMMY_LINES, `FSC_A_EXPOSURE,
    `FSC_A_GAIN, `FSC_A_SYNC_CFG};
  logic              clk = 1'h0;
  logic              link_clk = 1'h0;
  logic              resetn = 1'h0;
  logic [9:0]        pix = 10'h000;
  wire logic         sck, cs_n, mosi;
  logic              miso, miso_oe, fs, fb, fs_q;
  logic [15:0]       bla, blb;
  logic [9:0]        dout, sout, pq;
  fsc_pkg::fsc_act_t act, act_q;
  int                checks = 0;
  int                mismatches = 0;
  int                gap = 0;
  int                actv [5] = '{default: 0};

  always #10 clk = ~clk;
  always #6 link_clk = ~link_clk;
  always @(posedge link_clk) pix <= 10'($urandom);

  fsc_config_shadow #(.FRAME_CYCLES(FC)) dut (.clk(clk), .resetn(resetn),
    .ce(1'h1), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe(miso_oe), .black_level_a(bla),
    .black_level_b(blb), .link_clk(link_clk), .pix_data(pix),
    .data_out(dout), .sync_out(sout), .frame_start(fs),
    .frame_blank(fb), .act_cfg(act));
  fsc_spi_host host (.clk(clk), .spi_miso(miso), .spi_sck(sck),
    .spi_cs_n(cs_n), .spi_mosi(mosi));

  // active set moves only at a frame start; frames keep full length
  always @(posedge link_clk) begin
    if (resetn && act !== act_q && !fs && !fs_q)
      `CHK(act, act_q)
    if (resetn && sout !== `FSC_TRAIN_WORD) `CHK(dout, pq)
    if (fs === 1'h1 && gap > 0 && gap < 2 * FC) `CHK(gap, FC)
    gap = (fs === 1'h1) ? 1 : gap + 1;
    act_q <= act;
    fs_q <= fs;
    pq <= pix;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    logic [15:0] q;
    host.xfer(a, 1'h1, d, q);
  endtask

  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    logic [15:0] q;
    host.xfer(a, 1'h0, 16'h0000, q);
    `CHK(q, e)
    `CHK(miso_oe, 1'h0)
  endtask

  // returns one link cycle after the next frame start
  task automatic wfs();
    int n;
    n = 0;
    while (fs !== 1'h1 && n < 4 * FC) begin
      @(posedge link_clk);
      #1;
      n++;
    end
    if (n >= 4 * FC) mismatches++;
    @(posedge link_clk);
    #1;
  endtask

  // write early in a frame so it commits before the next start
  task automatic wrs(input logic [8:0] a, input logic [15:0] d);
    wfs();
    wr(a, d);
  endtask

  function automatic logic [15:0] fld(input int s);
    case (s)
      0: return act.exposure;
      1: return act.gain;
      2: return act.window;
      3: return act.black_lines;
      default: return act.dummy_lines;
    endcase
  endfunction

  // model: old value for n-1 frame starts, new value at the nth
  task automatic lat(input int s, input int n, input int v);
    for (int i = 1; i <= n; i++) begin
      wfs();
      `CHK(fld(s), 16'(i < n ? actv[s] : v))
      `CHK(sout, `FSC_SYNC_FS)
    end
    actv[s] = v;
  endtask

  task automatic blk(input int e);
    int nb;
    nb = 0;
    for (int i = 0; i < 3; i++) begin
      wfs();
      if (fb === 1'h1) begin
        nb++;
        repeat (FC / 2) @(posedge link_clk);
        #1;
        `CHK({dout, sout}, {2{`FSC_TRAIN_WORD}})
      end
    end
    `CHK(nb, e)
  endtask

  initial begin
    #1_000_000;
    mismatches++;
    wrap_up();
  end

  initial begin
    logic [15:0] r, g;
    int n;
    r = 16'($urandom(32'h1A97));
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 9; i++)
      rd(RA[i], RA[i] == `FSC_A_SYNC_CFG ? `FSC_RST_SYNC_CFG : 16'h0000);
    wr(9'h1F0, 16'hFFFF);
    rd(9'h1F0, 16'h0000);
    wr(`FSC_A_STATUS, 16'hFFFF);
    rd(`FSC_A_STATUS, 16'h0000);
    r = 16'($urandom);
    wr(`FSC_A_BLACK_LEVEL_A, r);
    `CHK(bla, r)
    wr(`FSC_A_BLACK_LEVEL_B, ~r);
    `CHK(blb, ~r)
    wr(`FSC_A_SEQ_CTRL, 16'h0001);
    wfs();
    host.xfer(`FSC_A_STATUS, 1'h0, 16'h0000, r);
    `CHK(r[0], 1'h1)
    g = 16'($urandom);
    wrs(`FSC_A_GAIN, g);
    lat(1, 2, g);
    r = 16'($urandom) & 16'hCFFF;
    wrs(`FSC_A_EXPOSURE, r);
    lat(0, 3, r);
    r = (16'($urandom) & 16'hCFFF) | 16'h2000;
    wrs(`FSC_A_EXPOSURE, r);
    lat(0, 3, r);
    g = 16'($urandom);
    wrs(`FSC_A_GAIN, g);
    lat(1, 3, g);
    wrs(`FSC_A_SYNC_CFG, 16'h002E);
    g = ~g;
    wrs(`FSC_A_GAIN, g);
    lat(1, 3, actv[1]);
    wrs(`FSC_A_SYNC_CFG, 16'h003E);
    repeat (4) wfs();
    `CHK(act.gain, g)
    wrs(`FSC_A_DUMMY_LINES, 16'($urandom) | 16'h0001);
    blk(0);
    wrs(`FSC_A_SEQ_CTRL, 16'h0000);
    repeat (2 * FC) @(posedge link_clk);
    n = 0;
    repeat (2 * FC) begin
      @(posedge link_clk);
      if (fs === 1'h1) n++;
    end
    `CHK(n, 0)
    wr(`FSC_A_SEQ_CTRL, 16'h0002);
    wr(`FSC_A_SEQ_CTRL, 16'h0083);
    repeat (3) wfs();
    `CHK({act.rolling, act.subsample}, 2'h3)
    wrs(`FSC_A_BLACK_LINES, 16'($urandom) | 16'h0001);
    blk(1);
    r = 16'($urandom) | 16'h0001;
    wrs(`FSC_A_WIN_SEL, r);
    blk(0);
    wrs(`FSC_A_SYNC_CFG, 16'h013E);
    wrs(`FSC_A_WIN_SEL, r ^ 16'h0001);
    blk(1);
    wrs(`FSC_A_WIN_SEL, r ^ 16'h0001);
    blk(0);
    wrs(`FSC_A_SEQ_CTRL, 16'h0001);
    wfs();
    `CHK(act.subsample, 1'h1)
    wfs();
    `CHK({act.rolling, act.subsample}, 2'h2)
    wrs(`FSC_A_SEQ_CTRL, 16'h0000);
    repeat (FC) @(posedge link_clk);
    wr(`FSC_A_SEQ_CTRL, 16'h0004);
    wr(`FSC_A_SEQ_CTRL, 16'h0005);
    r = (16'($urandom) & 16'hCFFF) | 16'h1000;
    wrs(`FSC_A_EXPOSURE, r);
    lat(0, 2, r);
    wrap_up();
  end
endmodule // tb_frame_synced_config_shadow

`default_nettype wire
